// ---- src/hlmmu_unit.sv ----
// Multiply, multiply-add and result/system-control move datapath
// Notes on behaviour
// - Short multiply-add: opcode zero, function 101000, bits 15..6 zero.
// - Short multiply-add treats both operands as signed 16-bit values.
// - Operands must be sign-extended 15-bit; otherwise result is unpredictable.
// - Product added to 64-bit upper:bottom accumulator; no overflow exception.
// - Short multiply-add waits 4, 36 or 68 cycles after wide product/divides.
// - Waits 1 after products, 2 after result reads, 0 after multiply-adds.
// - System read: fetch register at T, write general register at T+1, sign-extended in 64-bit mode, zero-extended otherwise.
// - System write: take general register at T, write control register at T+1.
// - Loads, stores and table operations around a system write are undefined.
// - User or supervisor system move without unit enabled raises coprocessor-unusable.
// - Upper read copies the upper result into the destination at T.
// - Bottom read copies the bottom result into the destination at T.
// - Upper write loads the upper result at T; undefined at T-2 and T-1.
// - Signed product of 32-bit operands splits into bottom and upper halves.
// - Unsigned product splits the same way, with no overflow exception.
// - Not-or: opcode zero, function 100111, three fields, bits 10..6 zero.
// - Not-or combines both sources bitwise and writes the destination.
`timescale 1ns/1ps
`default_nettype none
`include "hlmmu_defines.svh"

module hlmmu_unit
   import hlmmu_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic issue_valid,
   input wire logic [31:0] instr,
   input wire logic [63:0] src_a,
   input wire logic [63:0] src_b,
   input wire logic mode_64,
   input wire logic user_or_supervisor,
   input wire logic sysctl_enabled,
   input wire logic [63:0] sysctl_rdata,
   output logic issue_ready,
   output logic [4:0] sysctl_addr,
   output logic sysctl_we,
   output logic [31:0] sysctl_wdata,
   output logic gpr_we,
   output logic [4:0] gpr_waddr,
   output logic [63:0] gpr_wdata,
   output logic exc_valid,
   output logic [4:0] exc_cause,
   output logic [31:0] upper_result_reg,
   output logic [31:0] bottom_result_reg
);

   ////////////////////////////////////////////////////////////////////////
   // Decode

   logic [5:0] opc;
   logic [5:0] fn;
   logic [4:0] rs_f;
   logic [4:0] rt_f;
   logic [4:0] rd_f;
   logic special;
   logic is_mac;
   logic is_signed_product_op;
   logic is_unsigned_product_op;
   logic is_wmult;
   logic is_div;
   logic is_wdiv;
   logic is_uread;
   logic is_bread;
   logic is_uwrite;
   logic is_bwrite;
   logic is_nor;
   logic is_sysrd;
   logic is_sysw;
   logic sys_denied;

   assign opc = instr[31:26];
   assign fn = instr[5:0];
   assign rs_f = instr[25:21];
   assign rt_f = instr[20:16];
   assign rd_f = instr[15:11];
   assign special = (opc == `HLMMU_OP_SPECIAL);
   assign is_mac = special && (fn == `HLMMU_FN_SHORT_MAC) && (instr[15:6] == 10'h000);
   assign is_signed_product_op = special && (fn == `HLMMU_FN_SIGNED_PRODUCT);
   assign is_unsigned_product_op = special && (fn == `HLMMU_FN_UNSIGNED_PRODUCT);
   assign is_wmult = special && ((fn == `HLMMU_FN_WIDE_PRODUCT) ||
                                 (fn == `HLMMU_FN_WIDE_UPRODUCT));
   assign is_div = special && ((fn == `HLMMU_FN_DIV) || (fn == `HLMMU_FN_DIVU));
   assign is_wdiv = special && ((fn == `HLMMU_FN_WIDE_DIV) || (fn == `HLMMU_FN_WIDE_DIVU));
   assign is_uread = special && (fn == `HLMMU_FN_UPPER_READ);
   assign is_bread = special && (fn == `HLMMU_FN_BOTTOM_READ);
   assign is_uwrite = special && (fn == `HLMMU_FN_UPPER_WRITE);
   assign is_bwrite = special && (fn == `HLMMU_FN_BOTTOM_WRITE);
   assign is_nor = special && (fn == `HLMMU_FN_NOR) && (instr[10:6] == 5'h00);
   assign is_sysrd = (opc == `HLMMU_OP_SYSCTL) && (rs_f == `HLMMU_MOVE_FROM_CODE);
   assign is_sysw = (opc == `HLMMU_OP_SYSCTL) && (rs_f == `HLMMU_MOVE_TO_CODE);
   assign sys_denied = user_or_supervisor && !sysctl_enabled;

   ////////////////////////////////////////////////////////////////////////
   // Arithmetic

   logic signed [31:0] mac_prod;
   logic [63:0] mac_sum;
   logic [63:0] sprod;
   logic [63:0] uprod;

   // Only the low 16 bits are used; wider inputs give the unpredictable result allowed
   assign mac_prod = 32'($signed(src_a[15:0])) * 32'($signed(src_b[15:0]));
   assign mac_sum = {upper_result_reg, bottom_result_reg} +
                    {{32{mac_prod[31]}}, mac_prod};
   assign sprod = 64'($signed(src_a[31:0])) * 64'($signed(src_b[31:0]));
   assign uprod = {32'h00000000, src_a[31:0]} * {32'h00000000, src_b[31:0]};

   ////////////////////////////////////////////////////////////////////////
   // Interlock and control

   hlmmu_state_t state_reg;
   hlmmu_state_t state_next;
   logic [6:0] gap_reg;
   logic [6:0] gap_next;
   logic [6:0] need_reg;
   logic [6:0] need_next;
   logic [4:0] dest_reg;
   logic [4:0] dest_next;
   logic [31:0] hold_reg;
   logic [31:0] hold_next;
   logic [31:0] upper_next;
   logic [31:0] bottom_next;
   logic gpr_we_next;
   logic [4:0] gpr_waddr_next;
   logic [63:0] gpr_wdata_next;
   logic [4:0] sysctl_addr_next;
   logic sysctl_we_next;
   logic exc_next;
   logic mac_blocked;
   logic take;

   // Stalls a multiply-add until the producer's separation has elapsed
   assign mac_blocked = is_mac && (gap_reg < need_reg);
   assign issue_ready = (state_reg == HLMMU_ST_IDLE) && !mac_blocked;
   assign take = issue_valid && issue_ready;

   always_comb begin
      state_next = state_reg;
      gap_next = (gap_reg == 7'h7F) ? gap_reg : gap_reg + 7'h01;
      need_next = need_reg;
      dest_next = dest_reg;
      hold_next = hold_reg;
      upper_next = upper_result_reg;
      bottom_next = bottom_result_reg;
      gpr_we_next = 1'b0;
      gpr_waddr_next = gpr_waddr;
      gpr_wdata_next = gpr_wdata;
      sysctl_we_next = 1'b0;
      exc_next = 1'b0;
      sysctl_addr_next = (take && (is_sysrd || is_sysw)) ? rd_f : sysctl_addr;
      case (state_reg)
         HLMMU_ST_IDLE: begin
            if (take) begin
               if (is_mac) begin
                  {upper_next, bottom_next} = mac_sum;
                  gap_next = 7'h01;
                  need_next = 7'h00;
               end else if (is_signed_product_op || is_unsigned_product_op) begin
                  {upper_next, bottom_next} = is_signed_product_op ? sprod : uprod;
                  gap_next = 7'h01;
                  need_next = `HLMMU_GAP_PRODUCT;
               end else if (is_wmult) begin
                  gap_next = 7'h01;
                  need_next = `HLMMU_GAP_WIDE_PRODUCT;
               end else if (is_div) begin
                  gap_next = 7'h01;
                  need_next = `HLMMU_GAP_DIV;
               end else if (is_wdiv) begin
                  gap_next = 7'h01;
                  need_next = `HLMMU_GAP_WIDE_DIV;
               end else if (is_uread || is_bread) begin
                  gpr_we_next = 1'b1;
                  gpr_waddr_next = rd_f;
                  gpr_wdata_next = is_uread ? {{32{upper_result_reg[31]}}, upper_result_reg}
                                            : {{32{bottom_result_reg[31]}},
                                               bottom_result_reg};
                  gap_next = 7'h01;
                  need_next = `HLMMU_GAP_READ;
               end else if (is_uwrite) begin
                  upper_next = src_a[31:0];
               end else if (is_bwrite) begin
                  bottom_next = src_a[31:0];
               end else if (is_nor) begin
                  gpr_we_next = 1'b1;
                  gpr_waddr_next = rd_f;
                  gpr_wdata_next = ~(src_a | src_b);
               end else if ((is_sysrd || is_sysw) && sys_denied) begin
                  exc_next = 1'b1;
               end else if (is_sysrd) begin
                  dest_next = rt_f;
                  hold_next = sysctl_rdata[31:0];
                  state_next = HLMMU_ST_SYSRD;
               end else if (is_sysw) begin
                  hold_next = src_b[31:0];
                  state_next = HLMMU_ST_SYSWR;
               end
            end
         end
         HLMMU_ST_SYSRD: begin
            gpr_we_next = 1'b1;
            gpr_waddr_next = dest_reg;
            gpr_wdata_next = mode_64 ? {{32{hold_reg[31]}}, hold_reg}
                                     : {32'h00000000, hold_reg};
            state_next = HLMMU_ST_IDLE;
         end
         HLMMU_ST_SYSWR: begin
            // Memory ops around this move are the pipeline's concern
            sysctl_we_next = 1'b1;
            state_next = HLMMU_ST_IDLE;
         end
         default: state_next = HLMMU_ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= HLMMU_ST_IDLE;
         gap_reg <= 7'h7F;
         need_reg <= 7'h00;
         dest_reg <= 5'h00;
         hold_reg <= `HLMMU_RESULT_RESET;
         upper_result_reg <= `HLMMU_RESULT_RESET;
         bottom_result_reg <= `HLMMU_RESULT_RESET;
         gpr_we <= 1'b0;
         gpr_waddr <= 5'h00;
         gpr_wdata <= 64'h0000000000000000;
         sysctl_we <= 1'b0;
         exc_valid <= 1'b0;
         sysctl_addr <= 5'h00;
      end else begin
         state_reg <= state_next;
         gap_reg <= gap_next;
         need_reg <= need_next;
         dest_reg <= dest_next;
         hold_reg <= hold_next;
         upper_result_reg <= upper_next;
         bottom_result_reg <= bottom_next;
         gpr_we <= gpr_we_next;
         gpr_waddr <= gpr_waddr_next;
         gpr_wdata <= gpr_wdata_next;
         sysctl_we <= sysctl_we_next;
         exc_valid <= exc_next;
         sysctl_addr <= sysctl_addr_next;
      end
   end

   assign sysctl_wdata = hold_reg;
   assign exc_cause = exc_valid ? `HLMMU_CAUSE_UNUSABLE : `HLMMU_CAUSE_NONE;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   property p_mac_wait_div;
      @(posedge clock) disable iff (!nrst)
      (take && is_div) ##1 (issue_valid && is_mac)[*1] |-> !issue_ready;
   endproperty
   a_mac_wait_div: assert property (p_mac_wait_div) else $error("mac after divide not stalled");

   property p_mac_no_wait;
      @(posedge clock) disable iff (!nrst)
      (take && is_mac) ##1 (state_reg == HLMMU_ST_IDLE && is_mac) |-> issue_ready;
   endproperty
   a_mac_no_wait: assert property (p_mac_no_wait) else $error("back to back mac stalled");

   property p_mac_sum;
      @(posedge clock) disable iff (!nrst)
      (take && is_mac) |=> ({upper_result_reg, bottom_result_reg} ==
         $past({upper_result_reg, bottom_result_reg}) +
         $past(64'(32'($signed(src_a[15:0])) * 32'($signed(src_b[15:0])))));
   endproperty
   a_mac_sum: assert property (p_mac_sum) else $error("mac accumulate wrong");

   property p_signed_product_op;
      @(posedge clock) disable iff (!nrst)
      (take && is_signed_product_op) |=> ({upper_result_reg, bottom_result_reg} ==
         $past(64'($signed(src_a[31:0]))) * $past(64'($signed(src_b[31:0]))));
   endproperty
   a_signed_product_op: assert property (p_signed_product_op) else $error("signed product wrong");

   property p_sysrd;
      @(posedge clock) disable iff (!nrst)
      (take && is_sysrd && !sys_denied) |=> !gpr_we ##1 (gpr_we && gpr_waddr == $past(rt_f, 2));
   endproperty
   a_sysrd: assert property (p_sysrd) else $error("system read not written at T+1");

   property p_sysw;
      @(posedge clock) disable iff (!nrst)
      (take && is_sysw && !sys_denied) |=> ##1 (sysctl_we && sysctl_wdata == $past(src_b[31:0], 2));
   endproperty
   a_sysw: assert property (p_sysw) else $error("system write late or wrong");

   property p_denied;
      @(posedge clock) disable iff (!nrst)
      (take && (is_sysrd || is_sysw) && sys_denied) |=> exc_valid ##1 (!sysctl_we && !gpr_we);
   endproperty
   a_denied: assert property (p_denied) else $error("unusable move not trapped");

   property p_uread;
      @(posedge clock) disable iff (!nrst)
      (take && is_uread) |=> (gpr_we && gpr_wdata[31:0] == $past(upper_result_reg));
   endproperty
   a_uread: assert property (p_uread) else $error("upper read wrong");

   property p_nor;
      @(posedge clock) disable iff (!nrst)
      (take && is_nor) |=> (gpr_we && gpr_wdata == ~($past(src_a) | $past(src_b)));
   endproperty
   a_nor: assert property (p_nor) else $error("nor result wrong");

   c_mac: cover property (@(posedge clock) disable iff (!nrst) take && is_mac ##1 take && is_mac);
   c_stall: cover property (@(posedge clock) disable iff (!nrst) issue_valid && mac_blocked);
   c_sysrd: cover property (@(posedge clock) disable iff (!nrst) take && is_sysrd ##2 gpr_we);
   c_exc: cover property (@(posedge clock) disable iff (!nrst) exc_valid);

endmodule
`default_nettype wire

// ---- common/hlmmu_defines.svh ----
// Constants for the upper/bottom result multiply and move unit
`ifndef HLMMU_DEFINES_SVH
`define HLMMU_DEFINES_SVH
`define HLMMU_OP_SPECIAL 6'h00
`define HLMMU_OP_SYSCTL 6'h10
`define HLMMU_FN_SHORT_MAC 6'h28
`define HLMMU_FN_UPPER_READ 6'h10
`define HLMMU_FN_UPPER_WRITE 6'h11
`define HLMMU_FN_BOTTOM_READ 6'h12
`define HLMMU_FN_BOTTOM_WRITE 6'h13
`define HLMMU_FN_SIGNED_PRODUCT 6'h18
`define HLMMU_FN_UNSIGNED_PRODUCT 6'h19
`define HLMMU_FN_WIDE_PRODUCT 6'h1C
`define HLMMU_FN_WIDE_UPRODUCT 6'h1D
`define HLMMU_FN_DIV 6'h1A
`define HLMMU_FN_DIVU 6'h1B
`define HLMMU_FN_WIDE_DIV 6'h1E
`define HLMMU_FN_WIDE_DIVU 6'h1F
`define HLMMU_FN_NOR 6'h27
`define HLMMU_MOVE_FROM_CODE 5'h00
`define HLMMU_MOVE_TO_CODE 5'h04
`define HLMMU_GAP_PRODUCT 7'h01
`define HLMMU_GAP_READ 7'h02
`define HLMMU_GAP_WIDE_PRODUCT 7'h04
`define HLMMU_GAP_DIV 7'h24
`define HLMMU_GAP_WIDE_DIV 7'h44
`define HLMMU_RESULT_RESET 32'h00000000
`define HLMMU_CAUSE_NONE 5'h00
`define HLMMU_CAUSE_UNUSABLE 5'h0B
`endif

// ---- common/hlmmu_pkg.sv ----
// Types for the upper/bottom result multiply and move unit
package hlmmu_pkg;
   typedef enum logic [3:0] {
      HLMMU_ST_IDLE = 4'h1,
      HLMMU_ST_STALL = 4'h2,
      HLMMU_ST_SYSRD = 4'h4,
      HLMMU_ST_SYSWR = 4'h8
   } hlmmu_state_t;
endpackage

// ---- verification/hlmmu_sysctl_model.sv ----
// Behavioural system control register file on the far side of the unit
`timescale 1ns/1ps
`default_nettype none
module hlmmu_sysctl_model (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [4:0] sel,
   input wire logic we,
   input wire logic [4:0] waddr,
   input wire logic [31:0] wdata,
   output logic [63:0] rdata
);
   logic [63:0] regs [32];
   // Bit 31 set in every reset value so sign extension is visible
   assign rdata = regs[sel];
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 32; i++) begin
            regs[i] <= {32'h0, 32'h89ABCD00 | 32'(i)};
         end
      end else if (we) begin
         regs[waddr] <= {32'h0, wdata};
      end
   end
endmodule
`default_nettype wire

// ---- verification/hlmmu_unit_tb_top.sv ----
// Self-checking bench for the multiply and move unit
`timescale 1ns/1ps
`default_nettype none
`include "hlmmu_defines.svh"
module hlmmu_unit_tb_top;
   logic clock, nrst, issue_valid, mode_64, user_or_supervisor, sysctl_enabled;
   logic issue_ready, sysctl_we, gpr_we, exc_valid;
   logic [31:0] instr, sysctl_wdata, upper_result_reg, bottom_result_reg, d;
   logic [63:0] src_a, src_b, gpr_wdata, sysctl_rdata, acc, a, b;
   logic [4:0] sysctl_addr, gpr_waddr, exc_cause;
   logic [63:0] sreg [32];
   logic [69:0] q [$];
   logic [69:0] got;
   int err_count, checked, cyc, take_cyc, t0;
   logic [5:0] fnt [10] = '{`HLMMU_FN_WIDE_PRODUCT, `HLMMU_FN_WIDE_UPRODUCT, `HLMMU_FN_DIV,
      `HLMMU_FN_DIVU, `HLMMU_FN_WIDE_DIV, `HLMMU_FN_WIDE_DIVU, `HLMMU_FN_SIGNED_PRODUCT,
      `HLMMU_FN_UNSIGNED_PRODUCT, `HLMMU_FN_UPPER_READ, `HLMMU_FN_BOTTOM_READ};
   int nd [10] = '{4, 4, 36, 36, 68, 68, 1, 1, 2, 2};

   hlmmu_unit dut (.clock, .nrst, .issue_valid, .instr, .src_a, .src_b, .mode_64,
      .user_or_supervisor, .sysctl_enabled, .sysctl_rdata, .issue_ready, .sysctl_addr,
      .sysctl_we, .sysctl_wdata, .gpr_we, .gpr_waddr, .gpr_wdata, .exc_valid, .exc_cause,
      .upper_result_reg, .bottom_result_reg);
   hlmmu_sysctl_model sysctl (.clock(clock), .nrst(nrst), .sel(instr[15:11]),
      .we(sysctl_we), .waddr(sysctl_addr), .wdata(sysctl_wdata), .rdata(sysctl_rdata));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] sp(logic [4:0] sa, sb, dst, logic [5:0] fn);
      return {6'h00, sa, sb, dst, 5'h00, fn};
   endfunction
   function automatic logic [31:0] sc(logic [4:0] code, sb, dst);
      return {6'h10, code, sb, dst, 11'h000};
   endfunction
   function automatic logic [63:0] sx(logic [31:0] v);
      return {{32{v[31]}}, v};
   endfunction
   task automatic give_verdict();
      $display("Comparisons %0d, errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(logic [69:0] e, g);
      checked++;
      if (e !== g) begin
         err_count++;
         $display("ERROR at %0t: expected %0h got %0h", $time, e, g);
      end
   endtask
   task automatic put(logic [4:0] dst, logic [63:0] v);
      q.push_back({1'b0, dst, v});
   endtask
   // Leaves valid high so back-to-back issues need no idle edge
   task automatic issue(logic [31:0] ins, logic [63:0] x, y);
      int n = 0;
      instr = ins;
      src_a = x;
      src_b = y;
      issue_valid = 1'b1;
      #1;
      while (issue_ready !== 1'b1 && n < 300) begin
         @(posedge clock);
         #2;
         n++;
      end
      if (n == 300) chk(70'h0, 70'h1);
      @(posedge clock);
      take_cyc = cyc;
      #1;
   endtask
   task automatic idle(int n);
      issue_valid = 1'b0;
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Operands kept to sign-extended 15-bit values
   task automatic mac();
      int x, y;
      x = int'($urandom % 32768) - 16384;
      y = int'($urandom % 32768) - 16384;
      issue(sp(5'h01, 5'h02, 5'h00, `HLMMU_FN_SHORT_MAC), 64'(x), 64'(y));
      acc = acc + 64'(x * y);
   endtask
   task automatic mul(logic s);
      logic [31:0] x, y;
      x = $urandom;
      y = $urandom;
      issue(sp(5'h01, 5'h02, 5'h00,
         s ? `HLMMU_FN_UNSIGNED_PRODUCT : `HLMMU_FN_SIGNED_PRODUCT), sx(x), sx(y));
      acc = s ? {32'h0, x} * {32'h0, y} : 64'($signed(x)) * 64'($signed(y));
   endtask
   // Two fillers after the reads keep writers of the result pair away
   task automatic readback();
      issue(sp(5'h00, 5'h00, 5'h03, `HLMMU_FN_UPPER_READ), 64'h0, 64'h0);
      put(5'h03, sx(acc[63:32]));
      issue(sp(5'h00, 5'h00, 5'h04, `HLMMU_FN_BOTTOM_READ), 64'h0, 64'h0);
      put(5'h04, sx(acc[31:0]));
      repeat (2) begin
         a = {$urandom, $urandom};
         b = {$urandom, $urandom};
         issue(sp(5'h01, 5'h02, 5'h05, `HLMMU_FN_NOR), a, b);
         put(5'h05, ~(a | b));
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         give_verdict();
      end
   end
   // Sampled mid-cycle so each registered pulse is seen settled, once
   always @(negedge clock) begin
      if (nrst === 1'b1 && (gpr_we === 1'b1 || exc_valid === 1'b1)) begin
         got = {exc_valid, exc_valid ? exc_cause : gpr_waddr, exc_valid ? 64'h0 : gpr_wdata};
         if (q.size() == 0) chk(70'h0, got);
         else chk(q.pop_front(), got);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {nrst, issue_valid, mode_64, user_or_supervisor} = 4'h0;
      sysctl_enabled = 1'b1;
      {instr, src_a, src_b, acc} = '0;
      for (int i = 0; i < 32; i++) sreg[i] = {32'h0, 32'h89ABCD00 | 32'(i)};
      void'($urandom(32'hCFDC74FE));
      repeat (20) @(posedge clock);
      #1;
      nrst = 1'b1;
      mode_64 = 1'b1;
      d = $urandom;
      issue(sp(5'h01, 5'h00, 5'h00, `HLMMU_FN_UPPER_WRITE), sx(d), 64'h0);
      acc[63:32] = d;
      d = $urandom;
      issue(sp(5'h01, 5'h00, 5'h00, `HLMMU_FN_BOTTOM_WRITE), sx(d), 64'h0);
      acc[31:0] = d;
      readback();
      repeat (4) begin
         mul(1'($urandom % 2));
         readback();
      end
      repeat (3) begin
         t0 = take_cyc;
         mac();
         chk(70'h1, 70'(take_cyc - t0));
      end
      readback();
      for (int i = 0; i < 10; i++) begin
         issue(sp(5'h00, 5'h00, 5'(i > 7 ? 6 : 0), fnt[i]), 64'h0, 64'h0);
         t0 = take_cyc;
         if (i == 6 || i == 7) acc = 64'h0;
         if (i == 8) put(5'h06, sx(acc[63:32]));
         if (i == 9) put(5'h06, sx(acc[31:0]));
         mac();
         chk(70'(nd[i]), 70'(take_cyc - t0));
      end
      readback();
      // Reads of a control register wait until its last write has landed
      d = $urandom | 32'h80000000;
      issue(sc(`HLMMU_MOVE_TO_CODE, 5'h09, 5'h05), 64'h0, sx(d));
      for (int m = 0; m < 2; m++) begin
         idle(3);
         mode_64 = 1'(m);
         issue(sc(`HLMMU_MOVE_FROM_CODE, 5'h07, 5'h05), 64'h0, 64'h0);
         put(5'h07, m ? sx(d) : {32'h0, d});
      end
      for (int k = 0; k < 5; k++) begin
         idle(3);
         {sysctl_enabled, user_or_supervisor} = 2'(k == 4 ? 2 : k);
         d = $urandom;
         if (k < 4) issue(sc(`HLMMU_MOVE_TO_CODE, 5'h09, 5'h06), 64'h0, sx(d));
         if (k == 1) q.push_back({1'b1, `HLMMU_CAUSE_UNUSABLE, 64'h0});
         else if (k < 4) sreg[6] = {32'h0, d};
         idle(3);
         issue(sc(`HLMMU_MOVE_FROM_CODE, 5'h08, 5'h06), 64'h0, 64'h0);
         if (k == 1) q.push_back({1'b1, `HLMMU_CAUSE_UNUSABLE, 64'h0});
         else put(5'h08, sx(sreg[6][31:0]));
      end
      idle(6);
      chk(70'h0, 70'(q.size()));
      give_verdict();
   end
endmodule
`default_nettype wire
